// ==== common/cpsd_pkg.sv ====
// Contract
// - select-method pin: low manual, mid automatic non-revertive, high automatic revertive.
// - an undriven three-level pin reads as mid.
// - output-2 pin: low enabled, mid disabled, high bypass with output 2 enabled.
// - bypass and a CMOS shared format are never combined; a request for both is refused and flagged.
// - output-5 pin high powers down output 5 path and tristates it.
// - output-5 pin mid forces output 5 to CMOS, others keep shared format.
// - offset pin gates input-2 offset into selection: off, stratum 3/3E, SONET minimum.
// - input-1 active flag is 1 while input 1 feeds the loop.
// - input-2 active flag is 1 while input 2 feeds the loop.
// - two bandwidth pins form one code choosing the loop bandwidth.
// - two divider pins set output 3 and 4 ratio against output 2.
// - four ratio pins with table select choose input frequency and multiplication.
// - CMOS drives both pins of a pair alike; other formats are differential.
// - format pins: HM LVDS, HL CML, MH LVPECL, ML low-swing, LH CMOS, LM off.
// - shared format applies to outputs 1..4, and to output 5 while the output-5 pin is low.
// - manual mode: select pins 00..11 choose inputs 1..4.
// - input-invalid alarm rises on a missing clock, holds until input revalidated.
package cpsd_pkg;
   // three-level pin positions in the strap vectors
   localparam int NUM_TRI    = 15;
   localparam int TRI_SEL    = 0;
   localparam int TRI_OUT2   = 1;
   localparam int TRI_OUT5   = 2;
   localparam int TRI_FOS    = 3;
   localparam int TRI_BW0    = 4;
   localparam int TRI_BW1    = 5;
   localparam int TRI_DIV0   = 6;
   localparam int TRI_DIV1   = 7;
   localparam int TRI_RAT0   = 8;
   localparam int TRI_RAT1   = 9;
   localparam int TRI_RAT2   = 10;
   localparam int TRI_RAT3   = 11;
   localparam int TRI_TBL    = 12;
   localparam int TRI_FMT1   = 13;
   localparam int TRI_FMT0   = 14;
   localparam int NUM_IN     = 4;
   // synchronised pin vector layout: up, down, select, loss, valid, offset
   localparam int PIN_W      = 2 * NUM_TRI + 2 + 2 * NUM_IN + 1;
   localparam int PIN_DN     = NUM_TRI;
   localparam int PIN_CS     = 2 * NUM_TRI;
   localparam int PIN_LOSS   = PIN_CS + 2;
   localparam int PIN_VALID  = PIN_LOSS + NUM_IN;
   localparam int PIN_FOS    = PIN_VALID + NUM_IN;
   // level codes
   localparam logic [1:0] LVL_LOW  = 2'h0;
   localparam logic [1:0] LVL_MID  = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;
   // register map, byte addresses
   localparam logic [11:0] REG_LEVELS  = 12'h000;
   localparam logic [11:0] REG_CONFIG  = 12'h004;
   localparam logic [11:0] REG_STATUS  = 12'h008;
   localparam logic [11:0] REG_CONTROL = 12'h00c;
   localparam int CTRL_FREEZE = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {FMT_LVDS, FMT_CML, FMT_LVPECL, FMT_LVDS_LOW, FMT_CMOS, FMT_OFF, FMT_RESERVED}
      cpsd_format_t;
   typedef enum logic [1:0] {SEL_MANUAL, SEL_AUTO_NONREV, SEL_AUTO_REV} cpsd_selmode_t;
   typedef enum logic [1:0] {FOS_OFF, FOS_STRATUM3, FOS_SONET_MIN} cpsd_fos_t;

   typedef struct packed {
      cpsd_selmode_t selMode;
      cpsd_fos_t     fosMode;
      logic          out2Enable;
      logic          bypass;
      logic          comboError;
      logic          out5PowerDown;
      cpsd_format_t  sharedFormat;
      cpsd_format_t  out5Format;
      logic [4:0]    outCmos;
      logic [3:0]    bwCode;
      logic [3:0]    divCode;
      logic [6:0]    ratioCode;
      logic [1:0]    freqTable;
   } cpsd_cfg_t;

   // level of one pin from its two comparators; anything but a clean high or low is mid
   function automatic logic [1:0] cpsd_level(input logic up, input logic dn);
      if (up && !dn)
         return LVL_HIGH;
      if (dn && !up)
         return LVL_LOW;
      return LVL_MID;
   endfunction : cpsd_level

   // base-three value of two levels, first one most significant
   function automatic logic [3:0] cpsd_pair(input logic [1:0] hi, input logic [1:0] lo);
      return 4'(hi) * 4'h3 + 4'(lo);
   endfunction : cpsd_pair
endpackage : cpsd_pkg

// ==== verilog/cpsd_decoder.sv ====
`timescale 1ns/1ps
module cpsd_decoder (
   // clock and reset
   input  wire logic                    mclk,
   input  wire logic                    reset_n,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // three-level pins, as upper and lower comparator outputs
   input  wire logic [cpsd_pkg::NUM_TRI-1:0] levelUp,
   input  wire logic [cpsd_pkg::NUM_TRI-1:0] levelDn,
   // manual select pins and input monitors
   input  wire logic [1:0]              clockSelect,
   input  wire logic [3:0]              inputLoss,
   input  wire logic [3:0]              inputValidated,
   input  wire logic                    input2OffsetAlarm,
   // decoded configuration and indicators
   output cpsd_pkg::cpsd_cfg_t          cfg,
   output logic                         out5Tristate,
   output logic [1:0]                   activeInput,
   output logic                         input1_active_flag,
   output logic                         input2_active_flag,
   output logic [3:0]                   inputInvalid
);

   typedef struct packed {
      logic [cpsd_pkg::PIN_W-1:0] pinS1;
      logic [cpsd_pkg::PIN_W-1:0] pinS2;
      logic [cpsd_pkg::PIN_W-1:0] pinS3;
      logic [cpsd_pkg::PIN_W-1:0] pinStable;
      cpsd_pkg::cpsd_cfg_t        cfg;
      logic [3:0]                 alarm;
      logic [1:0]                 active;
      logic [31:0]                control;
      logic [31:0]                readData;
   } cpsd_state_t;

   cpsd_state_t st;
   cpsd_state_t next_st;

   logic [1:0]  lvl [cpsd_pkg::NUM_TRI];
   logic [3:0]  usable;
   logic [1:0]  firstUsable;
   logic        anyUsable;
   logic        addrHit;

   // level of every pin, from its settled comparator pair
   always_comb begin
      for (int i = 0; i < cpsd_pkg::NUM_TRI; i++) begin
         lvl[i] = cpsd_pkg::cpsd_level(st.pinStable[i], st.pinStable[cpsd_pkg::PIN_DN + i]);
      end
   end

   // inputs the selector may use: not alarmed, and input 2 clean of offset when gated in
   always_comb begin
      usable = ~st.alarm;
      if (st.cfg.fosMode != cpsd_pkg::FOS_OFF && st.pinStable[cpsd_pkg::PIN_FOS]) begin
         usable[1] = 1'b0;
      end
      anyUsable   = |usable;
      firstUsable = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (usable[i]) begin
            firstUsable = 2'(i);
         end
      end
   end

   always_comb begin
      addrHit = (paddr == cpsd_pkg::REG_LEVELS) || (paddr == cpsd_pkg::REG_CONFIG) ||
                (paddr == cpsd_pkg::REG_STATUS) || (paddr == cpsd_pkg::REG_CONTROL);
   end

   // next state of the whole block
   always_comb begin
      next_st = st;
      // three-flop pin capture; a change is taken once flops two and three agree
      next_st.pinS1 = {input2OffsetAlarm, inputValidated, inputLoss, clockSelect, levelDn, levelUp};
      next_st.pinS2 = st.pinS1;
      next_st.pinS3 = st.pinS2;
      for (int i = 0; i < cpsd_pkg::PIN_W; i++) begin
         if (st.pinS2[i] == st.pinS3[i]) begin
            next_st.pinStable[i] = st.pinS3[i];
         end
      end

      // selection method
      unique case (lvl[cpsd_pkg::TRI_SEL])
         cpsd_pkg::LVL_LOW:  next_st.cfg.selMode = cpsd_pkg::SEL_MANUAL;
         cpsd_pkg::LVL_HIGH: next_st.cfg.selMode = cpsd_pkg::SEL_AUTO_REV;
         default:            next_st.cfg.selMode = cpsd_pkg::SEL_AUTO_NONREV;
      endcase

      // offset qualification threshold
      unique case (lvl[cpsd_pkg::TRI_FOS])
         cpsd_pkg::LVL_LOW:  next_st.cfg.fosMode = cpsd_pkg::FOS_OFF;
         cpsd_pkg::LVL_HIGH: next_st.cfg.fosMode = cpsd_pkg::FOS_SONET_MIN;
         default:            next_st.cfg.fosMode = cpsd_pkg::FOS_STRATUM3;
      endcase

      // shared output format
      unique case ({lvl[cpsd_pkg::TRI_FMT1], lvl[cpsd_pkg::TRI_FMT0]})
         {cpsd_pkg::LVL_HIGH, cpsd_pkg::LVL_MID}:  next_st.cfg.sharedFormat = cpsd_pkg::FMT_LVDS;
         {cpsd_pkg::LVL_HIGH, cpsd_pkg::LVL_LOW}:  next_st.cfg.sharedFormat = cpsd_pkg::FMT_CML;
         {cpsd_pkg::LVL_MID, cpsd_pkg::LVL_HIGH}:  next_st.cfg.sharedFormat = cpsd_pkg::FMT_LVPECL;
         {cpsd_pkg::LVL_MID, cpsd_pkg::LVL_LOW}:   next_st.cfg.sharedFormat = cpsd_pkg::FMT_LVDS_LOW;
         {cpsd_pkg::LVL_LOW, cpsd_pkg::LVL_HIGH}:  next_st.cfg.sharedFormat = cpsd_pkg::FMT_CMOS;
         {cpsd_pkg::LVL_LOW, cpsd_pkg::LVL_MID}:   next_st.cfg.sharedFormat = cpsd_pkg::FMT_OFF;
         default:                                  next_st.cfg.sharedFormat = cpsd_pkg::FMT_RESERVED;
      endcase

      // output 2 enable and loop bypass
      next_st.cfg.out2Enable = lvl[cpsd_pkg::TRI_OUT2] != cpsd_pkg::LVL_MID;
      // bypass cannot drive a cmos pair, so such a request is refused and flagged
      next_st.cfg.comboError = (lvl[cpsd_pkg::TRI_OUT2] == cpsd_pkg::LVL_HIGH) &&
                               (next_st.cfg.sharedFormat == cpsd_pkg::FMT_CMOS);
      next_st.cfg.bypass     = (lvl[cpsd_pkg::TRI_OUT2] == cpsd_pkg::LVL_HIGH) &&
                               !next_st.cfg.comboError;

      // output 5 has its own override over the shared format
      next_st.cfg.out5PowerDown = lvl[cpsd_pkg::TRI_OUT5] == cpsd_pkg::LVL_HIGH;
      unique case (lvl[cpsd_pkg::TRI_OUT5])
         cpsd_pkg::LVL_LOW:  next_st.cfg.out5Format = next_st.cfg.sharedFormat;
         cpsd_pkg::LVL_HIGH: next_st.cfg.out5Format = cpsd_pkg::FMT_OFF;
         default:            next_st.cfg.out5Format = cpsd_pkg::FMT_CMOS;
      endcase

      // pair drive: outputs 1..4 follow the shared format, bit 4 is output 5
      next_st.cfg.outCmos[3:0] = {4{next_st.cfg.sharedFormat == cpsd_pkg::FMT_CMOS}};
      next_st.cfg.outCmos[4]   = next_st.cfg.out5Format == cpsd_pkg::FMT_CMOS;

      // lookup codes handed to the loop and dividers
      next_st.cfg.bwCode    = cpsd_pkg::cpsd_pair(lvl[cpsd_pkg::TRI_BW1], lvl[cpsd_pkg::TRI_BW0]);
      next_st.cfg.divCode   = cpsd_pkg::cpsd_pair(lvl[cpsd_pkg::TRI_DIV1], lvl[cpsd_pkg::TRI_DIV0]);
      next_st.cfg.ratioCode = 7'(cpsd_pkg::cpsd_pair(lvl[cpsd_pkg::TRI_RAT3], lvl[cpsd_pkg::TRI_RAT2])) * 7'h09
                            + 7'(cpsd_pkg::cpsd_pair(lvl[cpsd_pkg::TRI_RAT1], lvl[cpsd_pkg::TRI_RAT0]));
      next_st.cfg.freqTable = lvl[cpsd_pkg::TRI_TBL];

      // alarms: a loss in the same cycle as a revalidation keeps the alarm set
      for (int i = 0; i < 4; i++) begin
         if (st.pinStable[cpsd_pkg::PIN_LOSS + i]) begin
            next_st.alarm[i] = 1'b1;
         end else if (st.pinStable[cpsd_pkg::PIN_VALID + i]) begin
            next_st.alarm[i] = 1'b0;
         end
      end

      // active input; in the automatic modes, with no usable input the loop holds its last reference
      if (st.cfg.selMode == cpsd_pkg::SEL_MANUAL) begin
         next_st.active = st.pinStable[cpsd_pkg::PIN_CS +: 2];
      end else if (!st.control[cpsd_pkg::CTRL_FREEZE] && anyUsable) begin
         if (st.cfg.selMode == cpsd_pkg::SEL_AUTO_REV || !usable[st.active]) begin
            next_st.active = firstUsable;
         end
      end

      // apb: read data captured in setup, write taken in the access cycle
      if (psel && !penable) begin
         unique case (paddr)
            cpsd_pkg::REG_LEVELS:  next_st.readData = {2'h0, st.pinStable[cpsd_pkg::PIN_DN +: 15],
                                                       st.pinStable[14:0]};
            cpsd_pkg::REG_CONFIG:  next_st.readData = 32'(st.cfg);
            cpsd_pkg::REG_STATUS:  next_st.readData = {24'h0, st.alarm, 2'h0, st.active};
            cpsd_pkg::REG_CONTROL: next_st.readData = st.control;
            default:               next_st.readData = 32'h0;
         endcase
      end
      if (psel && penable && pwrite && paddr == cpsd_pkg::REG_CONTROL) begin
         next_st.control = {31'h0, pwdata[cpsd_pkg::CTRL_FREEZE]};
      end
   end

   // the only state register; pins reset to the undriven level
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
         st.cfg.selMode <= cpsd_pkg::SEL_AUTO_NONREV;
         st.cfg.fosMode <= cpsd_pkg::FOS_STRATUM3;
         st.cfg.sharedFormat <= cpsd_pkg::FMT_RESERVED;
         st.cfg.out5Format <= cpsd_pkg::FMT_CMOS;
         st.control <= cpsd_pkg::CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   // outputs
   assign cfg                = st.cfg;
   assign out5Tristate       = st.cfg.out5PowerDown;
   assign activeInput        = st.active;
   assign input1_active_flag = st.active == 2'h0;
   assign input2_active_flag = st.active == 2'h1;
   assign inputInvalid       = st.alarm;
   assign prdata             = st.readData;
   assign pready             = 1'b1;
   assign pslverr            = psel && penable && !addrHit;

   // checks
   a_select_manual: assert property (@(posedge mclk) disable iff (!reset_n)
      lvl[cpsd_pkg::TRI_SEL] == cpsd_pkg::LVL_LOW |=> cfg.selMode == cpsd_pkg::SEL_MANUAL)
      else $error("low select pin did not give manual mode");
   a_open_pin_mid: assert property (@(posedge mclk) disable iff (!reset_n)
      (!st.pinStable[cpsd_pkg::TRI_FOS] && !st.pinStable[cpsd_pkg::PIN_DN + cpsd_pkg::TRI_FOS])
      |=> cfg.fosMode == cpsd_pkg::FOS_STRATUM3)
      else $error("undriven offset pin not read as mid");
   a_out2_bypass: assert property (@(posedge mclk) disable iff (!reset_n)
      lvl[cpsd_pkg::TRI_OUT2] == cpsd_pkg::LVL_HIGH |=> cfg.out2Enable && (cfg.bypass != cfg.comboError))
      else $error("high output-2 pin mishandled");
   a_no_cmos_bypass: assert property (@(posedge mclk) disable iff (!reset_n)
      !(cfg.bypass && cfg.sharedFormat == cpsd_pkg::FMT_CMOS))
      else $error("bypass combined with cmos");
   a_out5_down: assert property (@(posedge mclk) disable iff (!reset_n)
      lvl[cpsd_pkg::TRI_OUT5] == cpsd_pkg::LVL_HIGH |=> out5Tristate && cfg.out5Format == cpsd_pkg::FMT_OFF)
      else $error("output 5 not powered down");
   a_out5_cmos: assert property (@(posedge mclk) disable iff (!reset_n)
      lvl[cpsd_pkg::TRI_OUT5] == cpsd_pkg::LVL_MID |=> cfg.outCmos[4] && !out5Tristate)
      else $error("output 5 not forced to cmos");
   a_fos_gate: assert property (@(posedge mclk) disable iff (!reset_n)
      (cfg.selMode == cpsd_pkg::SEL_AUTO_REV && cfg.fosMode != cpsd_pkg::FOS_OFF && st.alarm[0]
       && st.pinStable[cpsd_pkg::PIN_FOS] && !st.control[cpsd_pkg::CTRL_FREEZE] && anyUsable)
      |=> activeInput != 2'h1)
      else $error("offset input 2 was selected");
   a_flag_one: assert property (@(posedge mclk) disable iff (!reset_n)
      input1_active_flag |-> activeInput == 2'h0 && !input2_active_flag)
      else $error("input-1 flag wrong");
   a_alarm_hold: assert property (@(posedge mclk) disable iff (!reset_n)
      st.pinStable[cpsd_pkg::PIN_LOSS] |=> inputInvalid[0] [*1] ##0
      (inputInvalid[0] || $past(st.pinStable[cpsd_pkg::PIN_VALID])))
      else $error("input-1 alarm dropped");
   a_manual_pick: assert property (@(posedge mclk) disable iff (!reset_n)
      cfg.selMode == cpsd_pkg::SEL_MANUAL |=> activeInput == $past(st.pinStable[cpsd_pkg::PIN_CS +: 2]))
      else $error("manual select ignored");

   // indicator and lookup-code checks; fixed strap corners keep the expectations independent of the decode
   a_flag_two: assert property (@(posedge mclk) disable iff (!reset_n)
      input2_active_flag |-> activeInput == 2'h1 && !input1_active_flag)
      else $error("input-2 flag wrong");
   a_bw_code: assert property (@(posedge mclk) disable iff (!reset_n)
      lvl[cpsd_pkg::TRI_BW1] == cpsd_pkg::LVL_MID && lvl[cpsd_pkg::TRI_BW0] == cpsd_pkg::LVL_MID
      |=> cfg.bwCode == 4'h4)
      else $error("bandwidth code wrong");
   a_div_code: assert property (@(posedge mclk) disable iff (!reset_n)
      lvl[cpsd_pkg::TRI_DIV1] == cpsd_pkg::LVL_HIGH && lvl[cpsd_pkg::TRI_DIV0] == cpsd_pkg::LVL_HIGH
      |=> cfg.divCode == 4'h8)
      else $error("divider code wrong");
   a_ratio_code: assert property (@(posedge mclk) disable iff (!reset_n)
      lvl[cpsd_pkg::TRI_RAT3] == cpsd_pkg::LVL_HIGH && lvl[cpsd_pkg::TRI_RAT2] == cpsd_pkg::LVL_LOW &&
      lvl[cpsd_pkg::TRI_RAT1] == cpsd_pkg::LVL_LOW && lvl[cpsd_pkg::TRI_RAT0] == cpsd_pkg::LVL_LOW
      |=> cfg.ratioCode == 7'h36)
      else $error("ratio code wrong");

   // format checks: a cmos pair drives both pins alike, everything else stays differential
   a_fmt_cmos: assert property (@(posedge mclk) disable iff (!reset_n)
      lvl[cpsd_pkg::TRI_FMT1] == cpsd_pkg::LVL_LOW && lvl[cpsd_pkg::TRI_FMT0] == cpsd_pkg::LVL_HIGH
      |=> cfg.sharedFormat == cpsd_pkg::FMT_CMOS && cfg.outCmos[3:0] == 4'hf)
      else $error("cmos format not decoded");
   a_fmt_diff: assert property (@(posedge mclk) disable iff (!reset_n)
      cfg.sharedFormat != cpsd_pkg::FMT_CMOS |-> cfg.outCmos[3:0] == 4'h0)
      else $error("differential pair driven as cmos");
   a_out5_follow: assert property (@(posedge mclk) disable iff (!reset_n)
      lvl[cpsd_pkg::TRI_OUT5] == cpsd_pkg::LVL_LOW |=> cfg.out5Format == cfg.sharedFormat)
      else $error("output 5 left the shared format");
   a_out5_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
      out5Tristate |-> !cfg.outCmos[4])
      else $error("powered-down output 5 still driven");

   // alarm release and synchroniser agreement
   a_alarm_clear: assert property (@(posedge mclk) disable iff (!reset_n)
      !st.pinStable[cpsd_pkg::PIN_LOSS] && st.pinStable[cpsd_pkg::PIN_VALID] |=> !inputInvalid[0])
      else $error("input-1 alarm not released");
   a_sync_agree: assert property (@(posedge mclk) disable iff (!reset_n)
      st.pinS2[0] == st.pinS3[0] |=> st.pinStable[0] == $past(st.pinS3[0]))
      else $error("settled pin copy missed an agreed value");

endmodule : cpsd_decoder

// ==== verification/cpsd_strap_board.sv ====
`timescale 1ns/1ps
module cpsd_strap_board (
   // requested strap level per pin, two bits each: 0 low, 1 mid, 2 high, 3 left open
   input  wire logic [2*cpsd_pkg::NUM_TRI-1:0] strapLevel,
   // comparator view of each pin
   output logic      [cpsd_pkg::NUM_TRI-1:0]   levelUp,
   output logic      [cpsd_pkg::NUM_TRI-1:0]   levelDn
);
   // an open pin sits at mid through its weak bias pair, so neither comparator trips
   always_comb begin
      for (int i = 0; i < cpsd_pkg::NUM_TRI; i++) begin
         levelUp[i] = (strapLevel[2*i +: 2] == 2'h2);
         levelDn[i] = (strapLevel[2*i +: 2] == 2'h0);
      end
   end
endmodule : cpsd_strap_board

// ==== verification/cpsd_testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic                          mclk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic                          input2OffsetAlarm, flag1, flag2, out5Tristate, err;
   logic [11:0]                   paddr;
   logic [31:0]                   pwdata, prdata, rd;
   logic [1:0]                    clockSelect, activeInput, lv [cpsd_pkg::NUM_TRI];
   logic [3:0]                    inputLoss, inputValidated, inputInvalid;
   logic [2*cpsd_pkg::NUM_TRI-1:0] strapLevel;
   logic [cpsd_pkg::NUM_TRI-1:0]  levelUp, levelDn;
   cpsd_pkg::cpsd_cfg_t           cfg;
   int                            nMismatch = 0;
   int                            totalChecks = 0;

   cpsd_decoder cpsd_decoder_inst (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .levelUp(levelUp), .levelDn(levelDn), .clockSelect(clockSelect), .inputLoss(inputLoss),
      .inputValidated(inputValidated), .input2OffsetAlarm(input2OffsetAlarm), .cfg(cfg),
      .out5Tristate(out5Tristate), .activeInput(activeInput), .input1_active_flag(flag1),
      .input2_active_flag(flag2), .inputInvalid(inputInvalid));
   cpsd_strap_board cpsd_strap_board_inst (.strapLevel(strapLevel), .levelUp(levelUp), .levelDn(levelDn));

   // clock and strap packing
   always #2.5 mclk = ~mclk;
   always_comb for (int i = 0; i < cpsd_pkg::NUM_TRI; i++) strapLevel[2*i +: 2] = lv[i];

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run

   // one apb transfer; waits for pready with a bounded count, never assumes zero wait states
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) nMismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   function automatic cpsd_pkg::cpsd_format_t fmtExp(input logic [1:0] f1, input logic [1:0] f0);
      case ({f1, f0})
         4'h9: return cpsd_pkg::FMT_LVDS;
         4'h8: return cpsd_pkg::FMT_CML;
         4'h6: return cpsd_pkg::FMT_LVPECL;
         4'h4: return cpsd_pkg::FMT_LVDS_LOW;
         4'h2: return cpsd_pkg::FMT_CMOS;
         4'h1: return cpsd_pkg::FMT_OFF;
         default: return cpsd_pkg::FMT_RESERVED;
      endcase
   endfunction : fmtExp

   // let straps settle well past the synchroniser and decode latency, then compare every field
   task automatic checkCfg;
      logic [1:0] e [cpsd_pkg::NUM_TRI];
      cpsd_pkg::cpsd_format_t f;
      repeat (8) @(posedge mclk);
      for (int i = 0; i < cpsd_pkg::NUM_TRI; i++) e[i] = (lv[i] == 2'h3) ? cpsd_pkg::LVL_MID : lv[i];
      f = fmtExp(e[13], e[14]);
      chk(cfg.selMode, e[0]);
      chk(cfg.fosMode, e[3]);
      chk(cfg.sharedFormat, f);
      chk(cfg.out2Enable, e[1] != cpsd_pkg::LVL_MID);
      chk(cfg.bypass, e[1] == cpsd_pkg::LVL_HIGH && f != cpsd_pkg::FMT_CMOS);
      chk(cfg.comboError, e[1] == cpsd_pkg::LVL_HIGH && f == cpsd_pkg::FMT_CMOS);
      chk(out5Tristate, e[2] == cpsd_pkg::LVL_HIGH);
      if (e[2] == cpsd_pkg::LVL_MID) chk(cfg.out5Format, cpsd_pkg::FMT_CMOS);
      if (e[2] == cpsd_pkg::LVL_LOW) chk(cfg.out5Format, f);
      if (e[2] == cpsd_pkg::LVL_HIGH) chk(cfg.out5Format, cpsd_pkg::FMT_OFF);
      chk(cfg.outCmos[3:0], {4{f == cpsd_pkg::FMT_CMOS}});
      chk(cfg.outCmos[4], e[2] == cpsd_pkg::LVL_MID || (e[2] == cpsd_pkg::LVL_LOW && f == cpsd_pkg::FMT_CMOS));
      chk(cfg.bwCode, 3 * e[5] + e[4]);
      chk(cfg.divCode, 3 * e[7] + e[6]);
      chk(cfg.ratioCode, 9 * (3 * e[11] + e[10]) + 3 * e[9] + e[8]);
      chk(cfg.freqTable, e[12]);
      if (e[0] == cpsd_pkg::LVL_LOW) begin
         chk(activeInput, clockSelect);
         chk(flag1, clockSelect == 2'h0);
         chk(flag2, clockSelect == 2'h1);
      end
   endtask : checkCfg

   // watchdog: whole run is a few hundred cycles
   initial begin
      #100000;
      nMismatch++;
      complete_run();
   end

   initial begin
      mclk = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      clockSelect = 0; inputLoss = 0; inputValidated = 0; input2OffsetAlarm = 0;
      foreach (lv[i]) lv[i] = 2'h3;
      void'($urandom(92646));
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      checkCfg();
      $display("test open straps done");
      // every format code once per sweep, other straps random; bypass with cmos only in the last of the four sweeps
      for (int it = 0; it < 36; it++) begin
         @(posedge mclk);
         foreach (lv[i]) lv[i] <= 2'($urandom_range(3));
         lv[13] <= 2'((it % 9) / 3);
         lv[14] <= 2'(it % 3);
         clockSelect <= 2'($urandom_range(3));
         if (it % 9 == 2) lv[1] <= (it >= 27) ? 2'h2 : 2'h0;
         if (it % 9 == 5) lv[1] <= 2'h2;
         checkCfg();
      end
      $display("test random straps done");
      // manual select of each input
      for (int cs = 0; cs < 4; cs++) begin
         @(posedge mclk);
         lv[0] <= 2'h0;
         clockSelect <= 2'(cs);
         checkCfg();
      end
      $display("test manual select done");
      // revertive auto: lose input 1, then disqualify input 2 by offset, then revalidate
      @(posedge mclk);
      foreach (lv[i]) lv[i] <= 2'h1;
      lv[0] <= 2'h2;
      inputLoss <= 4'h1;
      checkCfg();
      chk(inputInvalid, 4'h1);
      chk(activeInput, 2'h1);
      chk(flag2, 1'b1);
      @(posedge mclk);
      inputLoss <= 4'h0;
      input2OffsetAlarm <= 1'b1;
      checkCfg();
      chk(inputInvalid, 4'h1);
      chk(activeInput, 2'h2);
      apb(1'b0, cpsd_pkg::REG_STATUS, 32'h0);
      chk(rd, 32'h12);
      @(posedge mclk);
      inputValidated <= 4'h1;
      input2OffsetAlarm <= 1'b0;
      repeat (4) @(posedge mclk);
      inputValidated <= 4'h0;
      checkCfg();
      chk(inputInvalid, 4'h0);
      chk(flag1, 1'b1);
      $display("test alarms done");
      // register bus: unmapped address, control round trip
      apb(1'b0, 12'h010, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, cpsd_pkg::REG_CONTROL, 32'h1);
      // frozen revertive selection must keep input 1 although it is lost
      @(posedge mclk);
      inputLoss <= 4'h1;
      checkCfg();
      chk(activeInput, 2'h0);
      apb(1'b0, cpsd_pkg::REG_CONTROL, 32'h0);
      chk(rd, 32'h1);
      chk(err, 1'b0);
      apb(1'b1, cpsd_pkg::REG_CONTROL, 32'h0);
      repeat (2) @(posedge mclk);
      chk(activeInput, 2'h1);
      chk(inputInvalid, 4'h1);
      $display("test register bus done");
      complete_run();
   end
endmodule : testbench
